/* hw/lre_engine.v */
// ladder relay evaluator: runs a rung program once per scan over a bit table
// assumes program and input loads come from logic on core_clk_i while busy_o is low
`timescale 1ns/100ps
`include "lre_map.vh"
module lre_engine #(
    parameter PROG_AW = 10
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire prog_wr_i,
    input wire [PROG_AW-1:0] prog_addr_i,
    input wire [`LRE_INSTR_W-1:0] prog_data_i,
    input wire in_wr_i,
    input wire [`LRE_REF_W-1:0] in_addr_i,
    input wire in_bit_i,
    input wire scan_start_i,
    output wire busy_o,
    output reg scan_done_o,
    output reg out_valid_o,
    output reg [`LRE_REF_W-1:0] out_addr_o,
    output reg out_bit_o,
    output reg func_exec_o,
    output reg [PROG_AW-1:0] func_pc_o,
    output reg prog_err_o,
    output reg [PROG_AW-1:0] err_pc_o
);
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_DEC = 3'h2;
    localparam S_EXEC = 3'h3;
    localparam S_ORD = 3'h4;
    localparam S_OWAIT = 3'h5;
    localparam S_OEMIT = 3'h6;

    // any output reference, main or auxiliary
    function is_out_ref;
        input [`LRE_REF_W-1:0] r;
        begin
            is_out_ref = (r <= `LRE_MAIN_OUT_HI) || (r >= `LRE_AUX_OUT_LO && r <= `LRE_AUX_OUT_HI);
        end
    endfunction

    // internal coils kept away from hardware
    function is_internal;
        input [`LRE_REF_W-1:0] r;
        begin
            is_internal = (r >= `LRE_INTERNAL_LO) && (r <= `LRE_INTERNAL_HI);
        end
    endfunction

    reg [2:0] state;
    reg [PROG_AW-1:0] pc;
    reg [`LRE_INSTR_W-1:0] instr;
    reg [7:0] line_pwr;
    reg [7:0] line_used;
    reg [7:0] line_has;
    reg [7:0] rst_mask;
    reg [`LRE_REF_W-1:0] sweep_addr;

    wire [`LRE_INSTR_W-1:0] prog_rdata;
    wire [`LRE_CELL_W-1:0] bit_rdata;
    wire [2:0] op;
    wire [2:0] ln;
    wire [3:0] col;
    wire rst_line;
    wire [`LRE_REF_W-1:0] ref_a;
    wire cell_state;
    wire cell_hist;
    wire rung_pwr;
    wire set_pwr;
    wire reset_pwr;

    assign op = instr[`LRE_OP_FIELD];
    assign ln = instr[`LRE_LINE_FIELD];
    assign col = instr[`LRE_COL_FIELD];
    assign rst_line = instr[`LRE_RSTLINE_BIT];
    assign ref_a = instr[`LRE_REF_FIELD];
    assign cell_state = bit_rdata[`LRE_STATE_BIT];
    assign cell_hist = bit_rdata[`LRE_HIST_BIT];
    assign busy_o = (state != S_IDLE);

    // rung results: any used line reaching the right rail
    assign rung_pwr = |(line_pwr & line_used);
    assign set_pwr = |(line_pwr & line_used & ~rst_mask);
    assign reset_pwr = |(line_pwr & line_used & rst_mask);

    // evaluation of one element, combinational
    reg next_wr;
    reg [`LRE_CELL_W-1:0] next_cell;
    reg next_err;
    reg next_pwr;
    reg next_func;
    reg next_rung_end;
    always @*
    begin
        next_wr = 1'b0;
        next_cell = bit_rdata;
        next_err = 1'b0;
        next_pwr = line_pwr[ln];
        next_func = 1'b0;
        next_rung_end = 1'b0;
        case (op)
            `LRE_OP_NO:
            begin
                if (col >= `LRE_CONTACT_COLS)
                    next_err = 1'b1;
                next_pwr = line_pwr[ln] & cell_state;
            end
            `LRE_OP_NC:
            begin
                if (col >= `LRE_CONTACT_COLS)
                    next_err = 1'b1;
                next_pwr = line_pwr[ln] & ~cell_state;
            end
            `LRE_OP_FUNC:
            begin
                if (line_has[ln])
                    next_pwr = line_pwr[ln];
                else
                    next_pwr = cell_state;
                next_func = next_pwr;
            end
            `LRE_OP_COIL:
            begin
                next_rung_end = 1'b1;
                if (col != `LRE_COIL_COL || ln != `LRE_FIRST_LINE || !is_out_ref(ref_a))
                    next_err = 1'b1;
                else
                begin
                    next_wr = 1'b1;
                    next_cell = {rung_pwr, rung_pwr};
                end
            end
            `LRE_OP_PULSE:
            begin
                next_rung_end = 1'b1;
                if (col != `LRE_COIL_COL || ln != `LRE_FIRST_LINE || !is_out_ref(ref_a))
                    next_err = 1'b1;
                else
                begin
                    next_wr = 1'b1;
                    next_cell = {rung_pwr, rung_pwr & ~cell_hist};
                end
            end
            `LRE_OP_LATCH:
            begin
                next_rung_end = 1'b1;
                if (col != `LRE_LATCH_COL || ln != `LRE_FIRST_LINE || !is_out_ref(ref_a))
                    next_err = 1'b1;
                else if (rst_mask == 8'h00)
                    next_err = 1'b1;
                else
                begin
                    next_wr = 1'b1;
                    if (reset_pwr)
                        next_cell = {set_pwr, 1'b0};
                    else if (set_pwr)
                        next_cell = {set_pwr, 1'b1};
                    else
                        next_cell = {set_pwr, cell_state};
                end
            end
            default:
            begin
                next_pwr = line_pwr[ln];
            end
        endcase
    end

    // memory port muxing: loads while idle, engine otherwise
    reg bit_we;
    reg [`LRE_REF_W-1:0] bit_addr;
    reg [`LRE_CELL_W-1:0] bit_wdata;
    always @*
    begin
        bit_we = 1'b0;
        bit_addr = ref_a;
        bit_wdata = next_cell;
        if (state == S_IDLE)
        begin
            bit_we = in_wr_i;
            bit_addr = in_addr_i;
            bit_wdata = {1'b0, in_bit_i};
        end
        else if (state == S_DEC)
            bit_addr = prog_rdata[`LRE_REF_FIELD];
        else if (state == S_EXEC)
            bit_we = next_wr;
        else if (state == S_ORD || state == S_OWAIT)
            bit_addr = sweep_addr;
    end

    wire prog_we;
    wire [PROG_AW-1:0] prog_addr;
    assign prog_we = (state == S_IDLE) & prog_wr_i;
    assign prog_addr = (state == S_IDLE) ? prog_addr_i : pc;

    lre_ram #(
        .WIDTH(`LRE_INSTR_W),
        .ADDR_W(PROG_AW)
    ) u_prog (
        .core_clk_i(core_clk_i),
        .we_i(prog_we),
        .addr_i(prog_addr),
        .wdata_i(prog_data_i),
        .rdata_o(prog_rdata)
    );

    lre_ram #(
        .WIDTH(`LRE_CELL_W),
        .ADDR_W(`LRE_REF_W)
    ) u_bits (
        .core_clk_i(core_clk_i),
        .we_i(bit_we),
        .addr_i(bit_addr),
        .wdata_i(bit_wdata),
        .rdata_o(bit_rdata)
    );

    // sequencer: fetch, decode, execute, then output sweep
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= S_IDLE;
            pc <= {PROG_AW{1'b0}};
            instr <= {`LRE_INSTR_W{1'b0}};
            line_pwr <= 8'hFF;
            line_used <= 8'h01;
            line_has <= 8'h00;
            rst_mask <= 8'h00;
            sweep_addr <= `LRE_MAIN_OUT_LO;
            scan_done_o <= 1'b0;
            out_valid_o <= 1'b0;
            out_addr_o <= `LRE_MAIN_OUT_LO;
            out_bit_o <= 1'b0;
            func_exec_o <= 1'b0;
            func_pc_o <= {PROG_AW{1'b0}};
            prog_err_o <= 1'b0;
            err_pc_o <= {PROG_AW{1'b0}};
        end
        else
        begin
            scan_done_o <= 1'b0;
            out_valid_o <= 1'b0;
            func_exec_o <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (scan_start_i)
                    begin
                        pc <= {PROG_AW{1'b0}};
                        prog_err_o <= 1'b0;
                        state <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    // program word appears next cycle
                    state <= S_DEC;
                end
                S_DEC:
                begin
                    instr <= prog_rdata;
                    if (prog_rdata[`LRE_OP_FIELD] == `LRE_OP_END)
                    begin
                        sweep_addr <= `LRE_MAIN_OUT_LO;
                        state <= S_ORD;
                    end
                    else
                        state <= S_EXEC;
                end
                S_EXEC:
                begin
                    if (next_err)
                    begin
                        prog_err_o <= 1'b1;
                        err_pc_o <= pc;
                    end
                    if (next_func)
                    begin
                        func_exec_o <= 1'b1;
                        func_pc_o <= pc;
                    end
                    // next rung starts fresh, table already updated
                    if (next_rung_end)
                    begin
                        line_pwr <= 8'hFF;
                        line_used <= 8'h01;
                        line_has <= 8'h00;
                        rst_mask <= 8'h00;
                    end
                    else
                    begin
                        line_pwr[ln] <= next_pwr;
                        line_used[ln] <= 1'b1;
                        line_has[ln] <= 1'b1;
                        if (rst_line)
                            rst_mask[ln] <= 1'b1;
                    end
                    pc <= pc + {{(PROG_AW-1){1'b0}}, 1'b1};
                    state <= S_FETCH;
                end
                S_ORD:
                begin
                    state <= S_OWAIT;
                end
                S_OWAIT:
                begin
                    state <= S_OEMIT;
                end
                S_OEMIT:
                begin
                    // final state only, sent after all rungs
                    if (!is_internal(sweep_addr))
                    begin
                        out_valid_o <= 1'b1;
                        out_addr_o <= sweep_addr;
                        out_bit_o <= bit_rdata[`LRE_STATE_BIT];
                    end
                    if (sweep_addr == `LRE_AUX_OUT_HI)
                    begin
                        scan_done_o <= 1'b1;
                        state <= S_IDLE;
                    end
                    else
                    begin
                        // jump over the input tables between the output ranges
                        if (sweep_addr == `LRE_MAIN_OUT_HI)
                            sweep_addr <= `LRE_AUX_OUT_LO;
                        else
                            sweep_addr <= sweep_addr + 12'h001;
                        state <= S_ORD;
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // lre_engine

/* hw/lre_map.vh */
// ladder relay evaluator: opcodes, instruction fields, grid limits and reference map
// assumes the includer works on one clock; definitions only, no logic
//
// How it works
// - normally open contact passes power when its bit is on, blocks it otherwise
// - normally closed contact passes power when its bit is off
// - normally closed contact with bit on blocks power
// - relay coil follows rung power every scan
// - repeated coil writes in a scan; only the last goes out at scan end
// - references O1001 to O1024 are internal and never forwarded
// - pulse coil stays on exactly one scan however long power lasts
// - pulse coil fires on an off-to-on edge of the whole rung result
// - another pulse needs rung power to drop and then return
// - pulse set in one scan turns off when its rung is met next scan
// - pulse coil references outside main or auxiliary outputs are rejected
// - latch sets and holds when its set line carries power
// - latch clears and holds when its reset line carries power
// - set and reset together: reset wins, latch off
// - contacts only in the first nine columns and eight lines
// - relay coils only in the tenth column of the first line
// - latch sits in the ninth column of the first line, two inputs only
// - latch rung with nothing on its reset line is invalid
// - left-rail function on reset line runs only while the latch is on
`ifndef LRE_MAP_VH
`define LRE_MAP_VH

// instruction word layout
`define LRE_INSTR_W 24
`define LRE_OP_FIELD 23:21
`define LRE_LINE_FIELD 20:18
`define LRE_COL_FIELD 17:14
`define LRE_RSTLINE_BIT 13
`define LRE_REF_FIELD 11:0

// opcodes
`define LRE_OP_END 3'h0
`define LRE_OP_NO 3'h1
`define LRE_OP_NC 3'h2
`define LRE_OP_COIL 3'h3
`define LRE_OP_PULSE 3'h4
`define LRE_OP_LATCH 3'h5
`define LRE_OP_FUNC 3'h6

// grid positions, columns counted from zero
`define LRE_CONTACT_COLS 4'h9
`define LRE_COIL_COL 4'h9
`define LRE_LATCH_COL 4'h8
`define LRE_FIRST_LINE 3'h0

// reference space, 12 bits
`define LRE_REF_W 12
`define LRE_MAIN_OUT_LO 12'h000
`define LRE_MAIN_OUT_HI 12'h3FF
`define LRE_INTERNAL_LO 12'h3E8
`define LRE_INTERNAL_HI 12'h3FF
`define LRE_AUX_OUT_LO 12'h800
`define LRE_AUX_OUT_HI 12'hBFF

// bit table word: state and last rung power
`define LRE_CELL_W 2
`define LRE_STATE_BIT 0
`define LRE_HIST_BIT 1

`endif

/* hw/lre_ram.v */
// single-port memory with registered read data
// assumes the owner never reads and writes the same cycle from two sources
`timescale 1ns/100ps
module lre_ram #(
    parameter WIDTH = 2,
    parameter ADDR_W = 12
) (
    input wire core_clk_i,
    input wire we_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

    // read returns old data on a write cycle; the engine never relies on it
    always @(posedge core_clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule // lre_ram

/* tb/lre_checker.sv */
// port timing checks for the ladder relay evaluator
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/100ps
`include "lre_map.vh"
module lre_checker #(
    parameter PROG_AW = 10
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire scan_start_i,
    input wire busy_o,
    input wire scan_done_o,
    input wire out_valid_o,
    input wire [`LRE_REF_W-1:0] out_addr_o,
    input wire func_exec_o,
    input wire prog_err_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // scan framing and output sweep
    done_idle_a: assert property (scan_done_o |=> !scan_done_o && !busy_o)
        else $error("done not followed by idle");
    valid_gap_a: assert property (out_valid_o |=> !out_valid_o [*2])
        else $error("output states closer than one address slot");
    out_range_a: assert property (out_valid_o |->
        out_addr_o <= `LRE_MAIN_OUT_HI || (out_addr_o >= `LRE_AUX_OUT_LO && out_addr_o <= `LRE_AUX_OUT_HI))
        else $error("state forwarded outside output tables");
    internal_hidden_a: assert property (out_valid_o |->
        !(out_addr_o >= `LRE_INTERNAL_LO && out_addr_o <= `LRE_INTERNAL_HI))
        else $error("internal coil forwarded");
    start_busy_a: assert property (scan_start_i && !busy_o |=> busy_o)
        else $error("scan start not taken");
    // error flag lives from one scan start to the next; a stuck flag would hide later faults
    err_clear_a: assert property (scan_start_i && !busy_o |=> !prog_err_o)
        else $error("error flag not cleared at start");
    err_hold_a: assert property (prog_err_o && !(scan_start_i && !busy_o) |=> prog_err_o)
        else $error("error flag dropped in scan");
    func_pulse_a: assert property (func_exec_o |-> busy_o ##1 !func_exec_o)
        else $error("function strobe outside scan or too long");

    // main scenarios
    done_c: cover property (scan_done_o);
    err_c: cover property (prog_err_o && scan_done_o);
    func_c: cover property (func_exec_o);
endmodule // lre_checker

bind lre_engine lre_checker #(.PROG_AW(PROG_AW)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .scan_start_i(scan_start_i), .busy_o(busy_o), .scan_done_o(scan_done_o), .out_valid_o(out_valid_o),
    .out_addr_o(out_addr_o), .func_exec_o(func_exec_o), .prog_err_o(prog_err_o));

/* tb/lre_engine_test.sv */
// self-checking bench: corner and random input scans over a fixed program, then faulty rungs
// assumes the checker is bound from its own file
`timescale 1ns/100ps
`include "lre_map.vh"
module lre_engine_test;
    reg core_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg prog_wr_i = 1'b0;
    reg [9:0] prog_addr_i = 10'h000;
    reg [23:0] prog_data_i = 24'h000000;
    reg in_wr_i = 1'b0;
    reg [11:0] in_addr_i = 12'h000;
    reg in_bit_i = 1'b0;
    reg scan_start_i = 1'b0;
    wire busy_o, scan_done_o, out_valid_o, out_bit_o, func_exec_o, prog_err_o;
    wire [11:0] out_addr_o;
    wire [9:0] func_pc_o, err_pc_o;
    integer n_fail = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer nval, pc, s, e, k;
    reg seen [0:4095];
    reg fhit [0:1023];
    reg [9:0] itab [0:4];
    reg [23:0] errw [0:19];
    reg [9:0] ib;
    reg pls, lat, last, prev;

    lre_engine #(.PROG_AW(10)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .prog_wr_i(prog_wr_i),
        .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .in_wr_i(in_wr_i), .in_addr_i(in_addr_i),
        .in_bit_i(in_bit_i), .scan_start_i(scan_start_i), .busy_o(busy_o), .scan_done_o(scan_done_o),
        .out_valid_o(out_valid_o), .out_addr_o(out_addr_o), .out_bit_o(out_bit_o),
        .func_exec_o(func_exec_o), .func_pc_o(func_pc_o), .prog_err_o(prog_err_o), .err_pc_o(err_pc_o));

    always #5 core_clk_i = ~core_clk_i;

    // hang guard: twelve scans of about 6200 cycles fit well inside
    always @(posedge core_clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 95000)
        begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end

    // pulses stand one cycle; the falling edge sees them settled
    always @(negedge core_clk_i)
    begin
        if (out_valid_o === 1'b1)
        begin
            seen[out_addr_o] = out_bit_o;
            nval = nval + 1;
        end
        if (func_exec_o === 1'b1)
            fhit[func_pc_o] = 1'b1;
    end

    function [23:0] ins(input [2:0] op, input [2:0] ln, input [3:0] col, input rf, input [11:0] rr);
        ins = {op, ln, col, rf, 1'b0, rr};
    endfunction
    function f_latch(input st, input rs, input q);
        f_latch = ~rs & (st | q);
    endfunction
    function f_pulse(input now, input was);
        f_pulse = now & ~was;
    endfunction

    task put(input [23:0] w);
    begin
        @(negedge core_clk_i);
        prog_wr_i = 1'b1;
        prog_addr_i = pc[9:0];
        prog_data_i = w;
        @(negedge core_clk_i);
        prog_wr_i = 1'b0;
        pc = pc + 1;
    end
    endtask
    task wbit(input [11:0] a, input v);
    begin
        @(negedge core_clk_i);
        in_wr_i = 1'b1;
        in_addr_i = a;
        in_bit_i = v;
        @(negedge core_clk_i);
        in_wr_i = 1'b0;
    end
    endtask
    // one contact on line zero feeding an end element
    task one(input [11:0] a, input [2:0] op, input [11:0] c);
    begin
        put(ins(`LRE_OP_NO, 3'h0, 4'h0, 1'b0, a));
        put(ins(op, 3'h0, 4'h9, 1'b0, c));
    end
    endtask
    task run_scan;
        integer t;
    begin
        nval = 0;
        for (t = 0; t < 1024; t = t + 1)
            fhit[t] = 1'b0;
        @(negedge core_clk_i);
        scan_start_i = 1'b1;
        @(negedge core_clk_i);
        scan_start_i = 1'b0;
        t = 0;
        while (scan_done_o !== 1'b1 && t < 8000)
        begin
            @(negedge core_clk_i);
            t = t + 1;
        end
        // a scan that never finishes counts as a mismatch here
        chk_bit("scan done", 1'b1, scan_done_o);
        @(negedge core_clk_i);
    end
    endtask
    task chk_bit(input string nm, input exp, input got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            $display("mismatch %0s expected %b seen %b", nm, exp, got);
            n_fail = n_fail + 1;
        end
    end
    endtask
    task chk_val(input string nm, input [15:0] exp, input [15:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            $display("mismatch %0s expected %0d seen %0d", nm, exp, got);
            n_fail = n_fail + 1;
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    initial
    begin
        k = $urandom(32'hA5585787);
        // corner scans: pulse rise, hold, hold, drop, rise; latch set, both, idle, set, idle
        itab[0] = 10'h2A1;
        itab[1] = 10'h1E3;
        itab[2] = 10'h044;
        itab[3] = 10'h088;
        itab[4] = 10'h030;
        for (k = 0; k < 20; k = k + 1)
            errw[k] = 24'h000000;
        errw[0] = ins(`LRE_OP_NO, 3'h0, 4'h9, 1'b0, 12'h400);
        errw[1] = ins(`LRE_OP_COIL, 3'h0, 4'h9, 1'b0, 12'h011);
        errw[4] = ins(`LRE_OP_NO, 3'h0, 4'h0, 1'b0, 12'h400);
        errw[5] = ins(`LRE_OP_COIL, 3'h0, 4'h8, 1'b0, 12'h010);
        errw[8] = errw[4];
        errw[9] = ins(`LRE_OP_PULSE, 3'h0, 4'h9, 1'b0, 12'h400);
        errw[12] = errw[4];
        errw[13] = ins(`LRE_OP_NO, 3'h1, 4'h0, 1'b1, 12'h401);
        errw[14] = ins(`LRE_OP_LATCH, 3'h0, 4'h9, 1'b0, 12'h010);
        errw[16] = errw[4];
        errw[17] = ins(`LRE_OP_LATCH, 3'h0, 4'h8, 1'b0, 12'h010);
        repeat (4) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        pc = 0;
        // program: functions land at words 23 and 24
        put(errw[4]);
        put(ins(`LRE_OP_NC, 3'h0, 4'h1, 1'b0, 12'h401));
        put(ins(`LRE_OP_NO, 3'h1, 4'h0, 1'b0, 12'h402));
        put(ins(`LRE_OP_COIL, 3'h0, 4'h9, 1'b0, 12'h002));
        one(12'h002, `LRE_OP_COIL, 12'h3E8);
        one(12'h3E8, `LRE_OP_COIL, 12'h008);
        one(12'h403, `LRE_OP_COIL, 12'h001);
        one(12'h404, `LRE_OP_COIL, 12'h001);
        one(12'h003, `LRE_OP_COIL, 12'h005);
        put(ins(`LRE_OP_NO, 3'h0, 4'h0, 1'b0, 12'h405));
        put(ins(`LRE_OP_NO, 3'h1, 4'h0, 1'b0, 12'h406));
        put(ins(`LRE_OP_PULSE, 3'h0, 4'h9, 1'b0, 12'h003));
        one(12'h003, `LRE_OP_COIL, 12'h004);
        put(ins(`LRE_OP_NO, 3'h0, 4'h0, 1'b0, 12'h407));
        put(ins(`LRE_OP_NO, 3'h1, 4'h0, 1'b1, 12'h408));
        put(ins(`LRE_OP_LATCH, 3'h0, 4'h8, 1'b0, 12'h006));
        put(ins(`LRE_OP_NO, 3'h0, 4'h0, 1'b0, 12'h409));
        put(ins(`LRE_OP_FUNC, 3'h0, 4'h1, 1'b0, 12'h000));
        put(ins(`LRE_OP_FUNC, 3'h1, 4'h0, 1'b0, 12'h006));
        put(ins(`LRE_OP_COIL, 3'h0, 4'h9, 1'b0, 12'h007));
        put(24'h000000);
        // memories start unknown: clear coils 0 to 16 and 3E8, every coil of the fixed program
        for (k = 0; k < 17; k = k + 1)
            wbit(k[11:0], 1'b0);
        wbit(12'h3E8, 1'b0);
        pls = 1'b0;
        lat = 1'b0;
        last = 1'b0;
        for (s = 0; s < 7; s = s + 1)
        begin
            k = $urandom;
            ib = (s < 5) ? itab[s] : k[9:0];
            for (k = 0; k < 10; k = k + 1)
                wbit(12'h400 | k[11:0], ib[k]);
            prev = pls;
            pls = f_pulse(ib[5] | ib[6], last);
            last = ib[5] | ib[6];
            lat = f_latch(ib[7], ib[8], lat);
            run_scan;
            chk_bit("coil 2", (ib[0] & ~ib[1]) | ib[2], seen[2]);
            chk_bit("coil 8", (ib[0] & ~ib[1]) | ib[2], seen[8]);
            chk_bit("coil 1", ib[4], seen[1]);
            chk_bit("coil 5", prev, seen[5]);
            chk_bit("pulse 3", pls, seen[3]);
            chk_bit("coil 4", pls, seen[4]);
            chk_bit("latch 6", lat, seen[6]);
            chk_bit("func 23", ib[9], fhit[23]);
            chk_bit("func 24", lat, fhit[24]);
            chk_val("states", 16'd2024, nval[15:0]);
            chk_bit("error", 1'b0, prog_err_o);
            $display("scan test %0d done", s);
        end
        wbit(12'h400, 1'b1);
        wbit(12'h401, 1'b1);
        // faulty rungs: contact col 9, coil col 8, pulse on input, latch col 9, no reset line
        for (e = 0; e < 5; e = e + 1)
        begin
            pc = 0;
            for (k = 0; k < 4; k = k + 1)
                put(errw[e * 4 + k]);
            run_scan;
            chk_bit("error", 1'b1, prog_err_o);
            chk_val("error pc", (e == 0) ? 16'd0 : (e == 3) ? 16'd2 : 16'd1, {6'h00, err_pc_o});
            chk_bit("coil 16", 1'b0, seen[16]);
            $display("fault test %0d done", e);
        end
        end_of_test;
    end
endmodule // lre_engine_test
